// ==== drbs_pkg.sv ====
// Constants for the DAC channel routing and bank switch block
package drbs_pkg;

  // Channel and sample layout
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned NUM_PAIR = 2;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SMP_W = 14;
  localparam int unsigned PERMIT_BIT = 15;
  localparam int unsigned SELECT_BIT = 14;

  // APB
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned IDX_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PAIR01_DIFF = 16'h7558;
  localparam logic [IDX_W-1:0] IDX_PAIR01_DUP = 16'h7559;
  localparam logic [IDX_W-1:0] IDX_CH0_BANK = 16'h7581;
  localparam logic [IDX_W-1:0] IDX_CH1_BANK = 16'h75E5;
  localparam logic [IDX_W-1:0] IDX_PAIR23_DIFF = 16'h7620;
  localparam logic [IDX_W-1:0] IDX_PAIR23_DUP = 16'h7621;
  localparam logic [IDX_W-1:0] IDX_CH2_BANK = 16'h7649;
  localparam logic [IDX_W-1:0] IDX_CH3_BANK = 16'h76AD;
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'h7700;

  // Status register fields
  localparam int unsigned STAT_BANK_LSB = 0;
  localparam int unsigned STAT_PAIR_AVAIL = 4;
  localparam int unsigned STAT_FOUR_CH = 5;

  // Values after reset
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_BANK = 1'b0;
  localparam logic [SMP_W-1:0] RST_SAMPLE = 14'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  function automatic logic [ADDR_W-1:0] byte_addr(
    input logic [IDX_W-1:0] idx
  );
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// ==== drbs_bank_sel.sv ====
// Per-channel bank selector for a multiplexed two-bank sample stream
`timescale 1ns/1ps
module drbs_bank_sel
  import drbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic enable_i,
  input wire logic bank_ext_i,
  // Stream
  input wire logic valid_i,
  input wire logic [WORD_W-1:0] sample_i,
  // Result
  output logic take_o,
  output logic [SMP_W-1:0] value_o,
  output logic bank_o
);

  logic phase_reg;
  logic bank_reg;
  logic bank_next;
  logic permit;

  assign permit = enable_i & valid_i & sample_i[PERMIT_BIT] & bank_ext_i;

  // Decided on the same edge as the sample itself
  always_comb begin
    bank_next = bank_reg;
    if (permit) begin
      bank_next = sample_i[SELECT_BIT];
    end
  end

  // Even stream positions carry bank a, odd ones bank b
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg <= 1'b0;
    end else if (!enable_i) begin
      phase_reg <= 1'b0;
    end else if (valid_i) begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_reg <= RST_BANK;
    end else begin
      bank_reg <= bank_next;
    end
  end

  // With switching enabled only the sample of the chosen bank reaches the DAC; disabled, every sample does
  assign take_o = valid_i & (~enable_i | (phase_reg == bank_next));
  assign value_o = sample_i[SMP_W-1:0];
  assign bank_o = bank_reg;

endmodule

// ==== drbs_top.sv ====
// DAC channel routing, pairing modes and bank switching with APB registers
//
// Contract
// - Differential: even gets sample, odd inverted
// - Both pair outputs from one stored sample
// - Two differential pairs only with four channels
// - Differential enable per pair, two registers
// - Double-out: odd copies even; pairs by channels
// - Double-out enable per pair, two registers
// - Bank switching per channel, own bank input
// - Bank switch enable register per channel
// - Stream alternates banks; output at half rate
// - Bit 15 and bank input permit switch
// - Bit 14 picks bank: low 0, high 1
// - Selected bank held while permission clear
// - Permission always set follows every bit 14
// - Without bank switching use bits 13..0 only
// - Interleaved channels handled independently
`timescale 1ns/1ps
module drbs_top
  import drbs_pkg::*;
#(
  parameter bit FOUR_CH_INSTALLED = 1'b1,
  parameter bit PAIR_MODES_AVAIL = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sample stream from memory
  input wire logic smp_valid_i,
  input wire logic [WORD_W-1:0] smp_ch0_i,
  input wire logic [WORD_W-1:0] smp_ch1_i,
  input wire logic [WORD_W-1:0] smp_ch2_i,
  input wire logic [WORD_W-1:0] smp_ch3_i,
  // External bank pins
  input wire logic [NUM_CH-1:0] bank_pin_i,
  // DAC side
  output logic [SMP_W-1:0] dac_ch0_o,
  output logic [SMP_W-1:0] dac_ch1_o,
  output logic [SMP_W-1:0] dac_ch2_o,
  output logic [SMP_W-1:0] dac_ch3_o,
  output logic [NUM_CH-1:0] dac_upd_o
);

  // Control registers
  logic [NUM_PAIR-1:0] diff_en_reg;
  logic [NUM_PAIR-1:0] dup_en_reg;
  logic [NUM_CH-1:0] bank_en_reg;

  // Bank pin synchroniser
  logic [NUM_CH-1:0] bank_meta_reg;
  logic [NUM_CH-1:0] bank_sync_reg;

  // APB answer registers
  logic [31:0] rdata_reg;
  logic slverr_reg;

  // Per-channel selector results
  logic [WORD_W-1:0] smp [NUM_CH];
  logic [NUM_CH-1:0] take;
  logic [SMP_W-1:0] value [NUM_CH];
  logic [NUM_CH-1:0] cur_bank;

  // Outputs
  logic [SMP_W-1:0] dac_reg [NUM_CH];
  logic [NUM_CH-1:0] upd_reg;

  // Capability per pair
  logic [NUM_PAIR-1:0] pair_ok;
  logic [NUM_PAIR-1:0] diff_eff;
  logic [NUM_PAIR-1:0] dup_eff;

  // APB decode
  logic setup_phase;
  logic wr_access;
  logic [IDX_W-1:0] idx;
  logic addr_aligned;
  logic [31:0] rd_value;
  logic rd_hit;

  function automatic logic [SMP_W-1:0] invert_sample(
    input logic [SMP_W-1:0] s
  );
    invert_sample = ~s;
  endfunction

  function automatic logic [31:0] flag_word(input logic f);
    flag_word = {31'h0000_0000, f};
  endfunction

  // Only variants with the pair feature get any pair; pair 2/3 needs ch2/3
  assign pair_ok[0] = PAIR_MODES_AVAIL;
  assign pair_ok[1] = PAIR_MODES_AVAIL & FOUR_CH_INSTALLED;
  assign diff_eff = diff_en_reg & pair_ok;
  // Differential takes precedence when both are set
  assign dup_eff = dup_en_reg & pair_ok & ~diff_en_reg;

  assign smp[0] = smp_ch0_i;
  assign smp[1] = smp_ch1_i;
  assign smp[2] = smp_ch2_i;
  assign smp[3] = smp_ch3_i;

  // Pins are asynchronous to the sample clock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_meta_reg <= '0;
      bank_sync_reg <= '0;
    end else begin
      bank_meta_reg <= bank_pin_i;
      bank_sync_reg <= bank_meta_reg;
    end
  end

  // One selector per channel, each with its own pin and enable
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    drbs_bank_sel u_sel (
      .clk_i (clk_i),
      .arst_n_i (arst_n_i),
      .enable_i (bank_en_reg[c]),
      .bank_ext_i (bank_sync_reg[c]),
      .valid_i (smp_valid_i),
      .sample_i (smp[c]),
      .take_o (take[c]),
      .value_o (value[c]),
      .bank_o (cur_bank[c])
    );
  end

  // Pair routing; odd channel's own stream is unused in pair modes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dac_reg[i] <= RST_SAMPLE;
      end
      upd_reg <= '0;
    end else begin
      for (int p = 0; p < NUM_PAIR; p++) begin
        upd_reg[2*p] <= take[2*p];
        if (take[2*p]) begin
          dac_reg[2*p] <= value[2*p];
        end
        if (diff_eff[p]) begin
          upd_reg[2*p+1] <= take[2*p];
          if (take[2*p]) begin
            dac_reg[2*p+1] <= invert_sample(value[2*p]);
          end
        end else if (dup_eff[p]) begin
          upd_reg[2*p+1] <= take[2*p];
          if (take[2*p]) begin
            dac_reg[2*p+1] <= value[2*p];
          end
        end else begin
          upd_reg[2*p+1] <= take[2*p+1];
          if (take[2*p+1]) begin
            dac_reg[2*p+1] <= value[2*p+1];
          end
        end
      end
    end
  end

  assign dac_ch0_o = dac_reg[0];
  assign dac_ch1_o = dac_reg[1];
  assign dac_ch2_o = dac_reg[2];
  assign dac_ch3_o = dac_reg[3];
  assign dac_upd_o = upd_reg;

  // APB: no wait states, answer prepared in the setup cycle
  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign idx = paddr_i[ADDR_W-1:2];
  assign addr_aligned = (paddr_i[1:0] == 2'b00);

  always_comb begin
    rd_value = RST_RDATA;
    rd_hit = addr_aligned;
    unique case (idx)
      IDX_PAIR01_DIFF: rd_value = flag_word(diff_en_reg[0]);
      IDX_PAIR23_DIFF: rd_value = flag_word(diff_en_reg[1]);
      IDX_PAIR01_DUP: rd_value = flag_word(dup_en_reg[0]);
      IDX_PAIR23_DUP: rd_value = flag_word(dup_en_reg[1]);
      IDX_CH0_BANK: rd_value = flag_word(bank_en_reg[0]);
      IDX_CH1_BANK: rd_value = flag_word(bank_en_reg[1]);
      IDX_CH2_BANK: rd_value = flag_word(bank_en_reg[2]);
      IDX_CH3_BANK: rd_value = flag_word(bank_en_reg[3]);
      IDX_STATUS: begin
        rd_value[STAT_BANK_LSB +: NUM_CH] = cur_bank;
        rd_value[STAT_PAIR_AVAIL] = PAIR_MODES_AVAIL;
        rd_value[STAT_FOUR_CH] = FOUR_CH_INSTALLED;
      end
      default: rd_hit = 1'b0;
    endcase
    if (!addr_aligned) begin
      rd_value = RST_RDATA;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= RST_RDATA;
      slverr_reg <= 1'b0;
    end else if (setup_phase) begin
      rdata_reg <= pwrite_i ? RST_RDATA : rd_value;
      // Status is read-only; writing it is an error
      slverr_reg <= ~rd_hit | (pwrite_i & (idx == IDX_STATUS));
    end
  end

  assign prdata_o = rdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = slverr_reg;

  // Pair enables: write is ignored where the variant lacks the mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diff_en_reg <= {NUM_PAIR{RST_ENABLE}};
      dup_en_reg <= {NUM_PAIR{RST_ENABLE}};
    end else if (wr_access && addr_aligned) begin
      if (idx == IDX_PAIR01_DIFF) begin
        diff_en_reg[0] <= pwdata_i[0] & pair_ok[0];
      end
      if (idx == IDX_PAIR23_DIFF) begin
        diff_en_reg[1] <= pwdata_i[0] & pair_ok[1];
      end
      if (idx == IDX_PAIR01_DUP) begin
        dup_en_reg[0] <= pwdata_i[0] & pair_ok[0];
      end
      if (idx == IDX_PAIR23_DUP) begin
        dup_en_reg[1] <= pwdata_i[0] & pair_ok[1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_en_reg <= {NUM_CH{RST_ENABLE}};
    end else if (wr_access && addr_aligned) begin
      unique case (idx)
        IDX_CH0_BANK: bank_en_reg[0] <= pwdata_i[0];
        IDX_CH1_BANK: bank_en_reg[1] <= pwdata_i[0];
        IDX_CH2_BANK: bank_en_reg[2] <= pwdata_i[0];
        IDX_CH3_BANK: bank_en_reg[3] <= pwdata_i[0];
        default: bank_en_reg <= bank_en_reg;
      endcase
    end
  end

endmodule

// ==== drbs_top_sva.sv ====
// Port-level assertions for the routing and bank switch block
`timescale 1ns/1ps
module drbs_top_sva
  import drbs_pkg::*;
(
  // Clock, reset and APB
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pslverr_o,
  // Stream and DAC
  input wire logic smp_valid_i,
  input wire logic [WORD_W-1:0] smp_ch0_i,
  input wire logic [SMP_W-1:0] dac_ch0_o,
  input wire logic [SMP_W-1:0] dac_ch1_o,
  input wire logic [SMP_W-1:0] dac_ch2_o,
  input wire logic [SMP_W-1:0] dac_ch3_o,
  input wire logic [NUM_CH-1:0] dac_upd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Shadow of the enables, taken from completed APB writes
  logic [3:0] en_reg;
  wire wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_reg <= 4'h0;
    end else if (wr) begin
      if (paddr_i == byte_addr(IDX_PAIR01_DIFF)) en_reg[0] <= pwdata_i[0];
      if (paddr_i == byte_addr(IDX_PAIR01_DUP)) en_reg[1] <= pwdata_i[0];
      if (paddr_i == byte_addr(IDX_CH0_BANK)) en_reg[2] <= pwdata_i[0];
      if (paddr_i == byte_addr(IDX_PAIR23_DIFF)) en_reg[3] <= pwdata_i[0];
    end
  end
  upd_cause_a: assert property (|dac_upd_o |-> $past(smp_valid_i))
    else $error("update without a sample");
  ch0_hold_a: assert property (!dac_upd_o[0] |-> $stable(dac_ch0_o))
    else $error("ch0 changed without update");
  plain_path_a: assert property (!en_reg[2] && $past(smp_valid_i) |->
    dac_upd_o[0] && dac_ch0_o == $past(smp_ch0_i[SMP_W-1:0]))
    else $error("ch0 plain sample wrong");
  diff_pair01_a: assert property (en_reg[0] && dac_upd_o[0] |->
    dac_upd_o[1] && dac_ch1_o == ~dac_ch0_o)
    else $error("pair01 not inverted");
  dup_pair01_a: assert property (en_reg[1] && !en_reg[0] && dac_upd_o[0]
    |-> dac_upd_o[1] && dac_ch1_o == dac_ch0_o)
    else $error("pair01 not copied");
  diff_pair23_a: assert property (en_reg[3] && dac_upd_o[2] |->
    dac_upd_o[3] && dac_ch3_o == ~dac_ch2_o)
    else $error("pair23 not inverted");
  status_ro_a: assert property (wr && paddr_i == byte_addr(IDX_STATUS)
    |-> pslverr_o)
    else $error("status write not refused");
  unmapped_err_a: assert property (psel_i && penable_i &&
    paddr_i == byte_addr(16'h0001) |-> pslverr_o)
    else $error("unmapped access not refused");
endmodule

bind drbs_top drbs_top_sva i_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pslverr_o(pslverr_o), .smp_valid_i(smp_valid_i), .smp_ch0_i(smp_ch0_i),
  .dac_ch0_o(dac_ch0_o), .dac_ch1_o(dac_ch1_o), .dac_ch2_o(dac_ch2_o),
  .dac_ch3_o(dac_ch3_o), .dac_upd_o(dac_upd_o));

// ==== drbs_mem_src.sv ====
// Sample memory stream and external bank pin source
`timescale 1ns/1ps
module drbs_mem_src
  import drbs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stream and pins
  output logic smp_valid_o = 1'b0,
  output logic [WORD_W-1:0] w0_o = 16'h0000,
  output logic [WORD_W-1:0] w1_o = 16'h0000,
  output logic [WORD_W-1:0] w2_o = 16'h0000,
  output logic [WORD_W-1:0] w3_o = 16'h0000,
  output logic [NUM_CH-1:0] bank_o = 4'h0
);
  bit busy = 1'b0;
  // Idle words toggle so a stale word never looks like a fresh sample
  always @(posedge clk_i) begin
    if (!busy) begin
      w0_o <= ~w0_o;
      w1_o <= ~w1_o;
      w2_o <= ~w2_o;
      w3_o <= ~w3_o;
    end
  end
  task automatic send(input logic [WORD_W-1:0] a, b, c, d);
    busy = 1'b1;
    @(posedge clk_i);
    smp_valid_o <= 1'b1;
    w0_o <= a;
    w1_o <= b;
    w2_o <= c;
    w3_o <= d;
  endtask
  task automatic stop;
    @(posedge clk_i);
    smp_valid_o <= 1'b0;
    busy = 1'b0;
  endtask
  task automatic pins(input logic [NUM_CH-1:0] p);
    @(posedge clk_i);
    bank_o <= p;
  endtask
endmodule

// ==== drbs_top_tb.sv ====
// Self-checking bench for the routing and bank switch block
`timescale 1ns/1ps
module drbs_top_tb
  import drbs_pkg::*;
;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, er;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic smp_v, pslverr_o;
  logic [WORD_W-1:0] w0, w1, w2, w3;
  logic [3:0] pins, upd;
  logic [SMP_W-1:0] d0, d1, d2, d3, q0[$], q1[$];
  int errors = 0, num_checks = 0;
  always #2 clk_i = ~clk_i;
  drbs_mem_src src (.clk_i(clk_i), .smp_valid_o(smp_v), .w0_o(w0),
    .w1_o(w1), .w2_o(w2), .w3_o(w3), .bank_o(pins));
  drbs_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .smp_valid_i(smp_v),
    .smp_ch0_i(w0), .smp_ch1_i(w1), .smp_ch2_i(w2), .smp_ch3_i(w3),
    .bank_pin_i(pins), .dac_ch0_o(d0), .dac_ch1_o(d1), .dac_ch2_o(d2),
    .dac_ch3_o(d3), .dac_upd_o(upd));
  always @(posedge clk_i) begin
    if (upd[0] === 1'b1) q0.push_back(d0);
    if (upd[1] === 1'b1) q1.push_back(d1);
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [IDX_W-1:0] i, d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {i, 2'b00};
    pwdata_i <= {16'h0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic run4(input logic [WORD_W-1:0] a0, a1, a2, a3);
    q0.delete();
    q1.delete();
    src.send(a0, 16'hC000, 16'h0000, 16'h0000);
    src.send(a1, 16'hC001, 16'h0000, 16'h0000);
    src.send(a2, 16'hC002, 16'h0000, 16'h0000);
    src.send(a3, 16'hC003, 16'h0000, 16'h0000);
    src.stop();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic q0chk(input int n, input logic [SMP_W-1:0] a, b);
    chk("ch0 count", n, q0.size());
    chk("ch0 first", a, q0[0]);
    chk("ch0 last", b, q0[n-1]);
  endtask
  task automatic one(input logic [WORD_W-1:0] a, c);
    src.send(a, 16'h1111, c, 16'h2222);
    src.stop();
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_regs;
    logic [IDX_W-1:0] ix [8] = '{IDX_PAIR01_DIFF, IDX_PAIR01_DUP,
      IDX_CH0_BANK, IDX_CH1_BANK, IDX_PAIR23_DIFF, IDX_PAIR23_DUP,
      IDX_CH2_BANK, IDX_CH3_BANK};
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, ix[k], 16'h0000);
      chk("reset value", 32'h0, rd);
      apb(1'b1, ix[k], 16'h0001);
      apb(1'b0, ix[k], 16'h0000);
      chk("read back", 32'h1, rd);
      apb(1'b1, ix[k], 16'h0000);
    end
    apb(1'b0, 16'h0001, 16'h0000);
    chk("unmapped error", 32'h1, er);
    apb(1'b1, IDX_STATUS, 16'h0000);
    chk("status error", 32'h1, er);
    apb(1'b0, IDX_STATUS, 16'h0000);
    chk("status", 32'h30, rd);
  endtask
  task automatic t_pair;
    apb(1'b1, IDX_PAIR01_DIFF, 16'h0001);
    apb(1'b1, IDX_PAIR23_DIFF, 16'h0001);
    one(16'h0005, 16'h0A00);
    chk("ch1 inverted", 32'h3FFA, d1);
    chk("ch3 inverted", 32'h35FF, d3);
    chk("ch2 even", 32'h0A00, d2);
    apb(1'b1, IDX_PAIR01_DIFF, 16'h0000);
    apb(1'b1, IDX_PAIR23_DIFF, 16'h0000);
    apb(1'b1, IDX_PAIR01_DUP, 16'h0001);
    apb(1'b1, IDX_PAIR23_DUP, 16'h0001);
    one(16'h0005, 16'h0A00);
    chk("ch1 copy", 32'h0005, d1);
    chk("ch3 copy", 32'h0A00, d3);
    apb(1'b1, IDX_PAIR01_DUP, 16'h0000);
    apb(1'b1, IDX_PAIR23_DUP, 16'h0000);
  endtask
  task automatic t_bank;
    run4(16'hC123, 16'h4001, 16'h8002, 16'h3FFF);
    q0chk(4, 14'h0123, 14'h3FFF);
    apb(1'b1, IDX_CH0_BANK, 16'h0001);
    run4(16'hC100, 16'hC101, 16'hC102, 16'hC103);
    q0chk(2, 14'h0100, 14'h0102);
    chk("ch1 count", 4, q1.size());
    chk("ch1 last", 3, q1[3]);
    src.pins(4'h1);
    repeat (3) @(posedge clk_i);
    // Permission only where bit 15 is set, now that pin 0 is high
    run4(16'hC000, 16'h0011, 16'h4000, 16'h0013);
    q0chk(2, 14'h0011, 14'h0013);
    run4(16'h8000, 16'h0021, 16'h4022, 16'h0023);
    q0chk(2, 14'h0000, 14'h0022);
    run4(16'h8030, 16'hC031, 16'h8032, 16'hC033);
    q0chk(4, 14'h0030, 14'h0033);
    apb(1'b1, IDX_CH0_BANK, 16'h0000);
    src.pins(4'h0);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_pair();
    t_bank();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule
